// *** pkg/vdm_pkg.sv ***
`default_nettype none
package vdm_pkg;

    // Printed register offsets are indices; byte address is four times the index
    localparam logic [7:0] VDM_IDX_LOOP   = 8'h2E;
    localparam logic [7:0] VDM_IDX_KILL   = 8'h2F;
    localparam logic [7:0] VDM_IDX_STAT   = 8'h30;
    localparam int         VDM_AW         = 8;
    localparam logic [7:0] VDM_ADDR_LOOP  = 8'hB8;
    localparam logic [7:0] VDM_ADDR_KILL  = 8'hBC;
    localparam logic [7:0] VDM_ADDR_STAT  = 8'hC0;

    // loop_speed_and_chroma_bw fields
    localparam int VDM_HLOOP_LSB  = 6;
    localparam int VDM_CGAIN_LSB  = 4;
    localparam int VDM_BURST_LSB  = 2;
    localparam int VDM_CBW_LSB    = 0;
    localparam logic [1:0] VDM_HLOOP_RST = 2'h2;
    localparam logic [1:0] VDM_CGAIN_RST = 2'h2;
    localparam logic [1:0] VDM_BURST_RST = 2'h1;
    localparam logic [1:0] VDM_CBW_RST   = 2'h1;
    localparam logic [7:0] VDM_LOOP_RST  = {VDM_HLOOP_RST, VDM_CGAIN_RST, VDM_BURST_RST, VDM_CBW_RST};

    // colour_killer_and_fill_control fields
    localparam int VDM_NTSC_KILL_BIT = 7;
    localparam int VDM_PAL_KILL_BIT  = 6;
    localparam int VDM_SECAM_KILL_BIT = 5;
    localparam int VDM_SPECIAL_BIT   = 4;
    localparam int VDM_FORCE_BIT     = 3;
    localparam int VDM_LOSS_BIT      = 2;
    localparam int VDM_FILL_SEL_BIT  = 1;
    localparam int VDM_BSTRETCH_BIT  = 0;
    localparam logic [7:0] VDM_KILL_RST = 8'hE0;

    // copy_protection_detect_status fields
    localparam int VDM_UNRELIABLE_BIT = 3;
    localparam int VDM_AGC_BIT        = 2;
    localparam int VDM_STRIPE_BIT     = 1;
    localparam int VDM_TYPE_BIT       = 0;
    localparam logic [3:0] VDM_STAT_RST = 4'h0;

    // Fill colours in YCbCr
    localparam logic [7:0] VDM_BLACK_Y  = 8'h10;
    localparam logic [7:0] VDM_BLACK_CB = 8'h80;
    localparam logic [7:0] VDM_BLACK_CR = 8'h80;
    localparam logic [7:0] VDM_BLUE_Y   = 8'h29;
    localparam logic [7:0] VDM_BLUE_CB  = 8'hF0;
    localparam logic [7:0] VDM_BLUE_CR  = 8'h6E;

    typedef enum logic [1:0] {
        VDM_HL_SLOW = 2'b00,
        VDM_HL_MID  = 2'b01,
        VDM_HL_AUTO = 2'b10,
        VDM_HL_FAST = 2'b11
    } vdm_hloop_t;

    typedef enum logic [1:0] {
        VDM_CG_OFF    = 2'b00,
        VDM_CG_SLOW   = 2'b01,
        VDM_CG_MEDIUM = 2'b10,
        VDM_CG_FAST   = 2'b11
    } vdm_cgain_t;

    typedef enum logic [1:0] {
        VDM_BL_SLOWEST = 2'b00,
        VDM_BL_SLOW    = 2'b01,
        VDM_BL_FAST    = 2'b10,
        VDM_BL_FASTEST = 2'b11
    } vdm_burst_t;

    typedef enum logic [1:0] {
        VDM_STD_NONE  = 2'b00,
        VDM_STD_NTSC  = 2'b01,
        VDM_STD_PAL   = 2'b10,
        VDM_STD_SECAM = 2'b11
    } vdm_std_t;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } vdm_pixel_t;

    typedef struct packed {
        vdm_hloop_t hloop_acquire_speed;
        vdm_cgain_t chroma_gain_time_const;
        logic       chroma_gain_on;
        vdm_burst_t burst_loop_speed;
        logic [1:0] chroma_lowpass_bw;
        logic       noise_killer_active;
        logic       special_output_sel;
        logic       blue_stretch_en;
        logic       fill_active;
    } vdm_ctrl_t;

    typedef struct packed {
        logic stripe_detect_unreliable;
        logic protect_agc_pulse_seen;
        logic stripe_burst_seen;
        logic stripe_protect_type;
    } vdm_detect_t;

endpackage
`default_nettype wire

// *** hw/vdm_reg8.sv ***
`timescale 1ns/1ps
`default_nettype none
module vdm_reg8
    import vdm_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00
)
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);

    always_ff @(posedge mclk)
    begin
        if (rst)
            q <= RESET_VALUE;
        else if (wr_en)
            q <= wdata;
    end

endmodule
`default_nettype wire

// *** hw/vdm_apb_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module vdm_apb_slave
    import vdm_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [VDM_AW-1:0] paddr,
    input  wire logic [7:0]        rd_byte,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [31:0]       prdata,
    output logic                   wr_loop,
    output logic                   wr_kill,
    output logic                   rd_hit_loop,
    output logic                   rd_hit_kill,
    output logic                   rd_hit_stat
);

    logic mapped;
    logic access;

    assign rd_hit_loop = (paddr == VDM_ADDR_LOOP);
    assign rd_hit_kill = (paddr == VDM_ADDR_KILL);
    assign rd_hit_stat = (paddr == VDM_ADDR_STAT);
    assign mapped      = rd_hit_loop | rd_hit_kill | rd_hit_stat;
    assign access      = psel & penable;

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = access;
    assign pslverr = access & ~mapped;
    assign wr_loop = access & pwrite & rd_hit_loop;
    assign wr_kill = access & pwrite & rd_hit_kill;

    // Read data captured in the setup cycle, held through the access phase
    always_ff @(posedge mclk)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable)
            prdata <= (~pwrite & mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end

endmodule
`default_nettype wire

// *** hw/vdm_misc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module vdm_misc_regs
    import vdm_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [VDM_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [31:0]       prdata,
    input  wire vdm_std_t          std_sel,
    input  wire logic              video_loss,
    input  wire logic              noisy_signal,
    input  wire vdm_detect_t       detect_in,
    input  wire logic              pix_valid_in,
    input  wire vdm_pixel_t        pix_in,
    output logic                   pix_valid_out,
    output vdm_pixel_t             pix_out,
    output vdm_ctrl_t              ctrl,
    output logic                   colour_kill
);

    logic [7:0]  loop_speed_and_chroma_bw;
    logic [7:0]  colour_killer_and_fill_control;
    logic [7:0]  copy_protection_detect_status;
    vdm_detect_t detect;
    logic [7:0]  rd_byte;
    logic        wr_loop_bus;
    logic        wr_kill_bus;
    logic        hit_loop;
    logic        hit_kill;
    logic        hit_stat;
    logic        wr_loop;
    logic        wr_kill;

    logic        ntsc_noise_killer_en;
    logic        pal_noise_killer_en;
    logic        secam_noise_killer_en;
    logic        special_output_sel;
    logic        force_fill_colour;
    logic        loss_fill_colour_en;
    logic        fill_colour_select;
    logic        blue_stretch_en;

    logic        killer_for_std;
    logic        next_fill_active;
    vdm_pixel_t  fill_pixel;
    vdm_ctrl_t   next_ctrl;

    vdm_apb_slave u_apb
    (
        .mclk        (mclk),
        .rst         (rst),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .rd_byte     (rd_byte),
        .pready      (pready),
        .pslverr     (pslverr),
        .prdata      (prdata),
        .wr_loop     (wr_loop_bus),
        .wr_kill     (wr_kill_bus),
        .rd_hit_loop (hit_loop),
        .rd_hit_kill (hit_kill),
        .rd_hit_stat (hit_stat)
    );

    // Byte lane 0 carries the register; a write with lane 0 off changes nothing
    assign wr_loop = wr_loop_bus & pstrb[0];
    assign wr_kill = wr_kill_bus & pstrb[0];

    vdm_reg8 #(.RESET_VALUE(VDM_LOOP_RST)) u_loop_reg
    (
        .mclk  (mclk),
        .rst   (rst),
        .wr_en (wr_loop),
        .wdata (pwdata[7:0]),
        .q     (loop_speed_and_chroma_bw)
    );

    vdm_reg8 #(.RESET_VALUE(VDM_KILL_RST)) u_kill_reg
    (
        .mclk  (mclk),
        .rst   (rst),
        .wr_en (wr_kill),
        .wdata (pwdata[7:0]),
        .q     (colour_killer_and_fill_control)
    );

    assign ntsc_noise_killer_en  = colour_killer_and_fill_control[VDM_NTSC_KILL_BIT];
    assign pal_noise_killer_en   = colour_killer_and_fill_control[VDM_PAL_KILL_BIT];
    assign secam_noise_killer_en = colour_killer_and_fill_control[VDM_SECAM_KILL_BIT];
    assign special_output_sel    = colour_killer_and_fill_control[VDM_SPECIAL_BIT];
    assign force_fill_colour     = colour_killer_and_fill_control[VDM_FORCE_BIT];
    assign loss_fill_colour_en   = colour_killer_and_fill_control[VDM_LOSS_BIT];
    assign fill_colour_select    = colour_killer_and_fill_control[VDM_FILL_SEL_BIT];
    assign blue_stretch_en       = colour_killer_and_fill_control[VDM_BSTRETCH_BIT];

    // Detector levels are sampled once; the status follows them while present
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            detect <= vdm_detect_t'(VDM_STAT_RST);
        end
        else
        begin
            detect.stripe_detect_unreliable <= detect_in.stripe_detect_unreliable;
            detect.protect_agc_pulse_seen   <= detect_in.protect_agc_pulse_seen;
            detect.stripe_burst_seen        <= detect_in.stripe_burst_seen;
            // Type is only tracked while a stripe burst is seen; otherwise last value holds
            if (detect_in.stripe_burst_seen)
                detect.stripe_protect_type <= detect_in.stripe_protect_type;
        end
    end

    // Status has no write path at all
    assign copy_protection_detect_status = {4'h0, detect};

    always_comb
    begin
        rd_byte = 8'h00;
        if (hit_loop)
            rd_byte = loop_speed_and_chroma_bw;
        else if (hit_kill)
            rd_byte = colour_killer_and_fill_control;
        else if (hit_stat)
            rd_byte = copy_protection_detect_status;
    end

    // Per-standard noise killer selection
    always_comb
    begin
        case (std_sel)
            VDM_STD_NTSC:  killer_for_std = ntsc_noise_killer_en;
            VDM_STD_PAL:   killer_for_std = pal_noise_killer_en;
            VDM_STD_SECAM: killer_for_std = secam_noise_killer_en;
            default:       killer_for_std = 1'h0;
        endcase
    end

    assign next_fill_active = force_fill_colour | (loss_fill_colour_en & video_loss);

    always_comb
    begin
        if (fill_colour_select)
        begin
            fill_pixel.y  = VDM_BLUE_Y;
            fill_pixel.cb = VDM_BLUE_CB;
            fill_pixel.cr = VDM_BLUE_CR;
        end
        else
        begin
            fill_pixel.y  = VDM_BLACK_Y;
            fill_pixel.cb = VDM_BLACK_CB;
            fill_pixel.cr = VDM_BLACK_CR;
        end
    end

    // Decoded settings for the video path
    always_comb
    begin
        next_ctrl.hloop_acquire_speed    = vdm_hloop_t'(loop_speed_and_chroma_bw[VDM_HLOOP_LSB +: 2]);
        next_ctrl.chroma_gain_time_const = vdm_cgain_t'(loop_speed_and_chroma_bw[VDM_CGAIN_LSB +: 2]);
        next_ctrl.chroma_gain_on         = (next_ctrl.chroma_gain_time_const != VDM_CG_OFF);
        next_ctrl.burst_loop_speed       = vdm_burst_t'(loop_speed_and_chroma_bw[VDM_BURST_LSB +: 2]);
        next_ctrl.chroma_lowpass_bw      = loop_speed_and_chroma_bw[VDM_CBW_LSB +: 2];
        next_ctrl.noise_killer_active    = killer_for_std;
        next_ctrl.special_output_sel     = special_output_sel;
        next_ctrl.blue_stretch_en        = blue_stretch_en;
        next_ctrl.fill_active            = next_fill_active;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl <= vdm_ctrl_t'(0);
        else
            ctrl <= next_ctrl;
    end

    // Chroma is killed when the killer for this standard is on and the signal is noisy
    always_ff @(posedge mclk)
    begin
        if (rst)
            colour_kill <= 1'h0;
        else
            colour_kill <= killer_for_std & noisy_signal;
    end

    // Output pixel stage: fill replaces the incoming video
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pix_valid_out <= 1'h0;
            pix_out       <= vdm_pixel_t'(0);
        end
        else
        begin
            pix_valid_out <= pix_valid_in;
            if (pix_valid_in)
                pix_out <= next_fill_active ? fill_pixel : pix_in;
        end
    end

endmodule
`default_nettype wire

// *** bench/vdm_misc_regs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module vdm_misc_regs_checker
    import vdm_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [VDM_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [31:0]       prdata,
    input wire vdm_std_t          std_sel,
    input wire logic              video_loss,
    input wire logic              noisy_signal,
    input wire vdm_detect_t       detect_in,
    input wire logic              pix_valid_in,
    input wire vdm_pixel_t        pix_in,
    input wire logic              pix_valid_out,
    input wire vdm_pixel_t        pix_out,
    input wire vdm_ctrl_t         ctrl,
    input wire logic              colour_kill
);
    logic       wl;
    logic       wk;
    logic       rd;
    logic       kexp;
    logic [7:0] shl;
    logic [7:0] shk;
    vdm_pixel_t pexp;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    assign wl = psel && penable && pwrite && pstrb[0] && paddr == VDM_ADDR_LOOP;
    assign wk = psel && penable && pwrite && pstrb[0] && paddr == VDM_ADDR_KILL;
    assign rd = psel && !penable && !pwrite;
    assign kexp = noisy_signal && (std_sel == VDM_STD_NTSC ? shk[7] : std_sel == VDM_STD_PAL ? shk[6] :
                  std_sel == VDM_STD_SECAM && shk[5]);
    assign pexp = !(shk[3] || shk[2] && video_loss) ? pix_in :
                  shk[1] ? {VDM_BLUE_Y, VDM_BLUE_CB, VDM_BLUE_CR} : {VDM_BLACK_Y, VDM_BLACK_CB, VDM_BLACK_CR};

    // Shadow copies of the two writable registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            shl <= VDM_LOOP_RST;
            shk <= VDM_KILL_RST;
        end
        else
        begin
            if (wl)
                shl <= pwdata[7:0];
            if (wk)
                shk <= pwdata[7:0];
        end
    end

    a_hloop_speed: assert property (wl |-> ##2 ctrl.hloop_acquire_speed == $past(pwdata[7:6], 2))
        else $error("hloop speed not taken from write");
    a_chroma_gain: assert property (wl |-> ##2 ctrl.chroma_gain_time_const == $past(pwdata[5:4], 2)
        && ctrl.chroma_gain_on == |$past(pwdata[5:4], 2)) else $error("chroma gain decode wrong");
    a_burst_bw: assert property (wl |-> ##2 {ctrl.burst_loop_speed, ctrl.chroma_lowpass_bw} == $past(pwdata[3:0], 2))
        else $error("burst speed or bandwidth wrong");
    a_mode_bits: assert property (wk |-> ##2 ctrl.special_output_sel == $past(pwdata[4], 2)
        && ctrl.blue_stretch_en == $past(pwdata[0], 2)) else $error("mode bits wrong");
    a_killer_std: assert property (!wk |=> colour_kill == $past(kexp))
        else $error("colour killer wrong");
    a_fill_colour: assert property (pix_valid_in && !wk |=> pix_valid_out && pix_out == $past(pexp))
        else $error("pixel fill wrong");
    a_reg_readback: assert property (rd && (paddr == VDM_ADDR_LOOP || paddr == VDM_ADDR_KILL)
        |=> prdata == {24'h0, paddr == VDM_ADDR_LOOP ? shl : shk}) else $error("readback wrong");
    a_status_read: assert property (rd && paddr == VDM_ADDR_STAT && !$past(rst)
        |=> prdata[31:1] == {28'h0, $past(detect_in[3:1], 2)}) else $error("status read wrong");

    c_loop_write: cover property (wl);
    c_fill_forced: cover property (pix_valid_in && shk[3]);
    c_stat_read: cover property (psel && penable && paddr == VDM_ADDR_STAT);
endmodule

bind vdm_misc_regs vdm_misc_regs_checker u_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .std_sel(std_sel), .video_loss(video_loss), .noisy_signal(noisy_signal),
    .detect_in(detect_in), .pix_valid_in(pix_valid_in), .pix_in(pix_in), .pix_valid_out(pix_valid_out),
    .pix_out(pix_out), .ctrl(ctrl), .colour_kill(colour_kill));
`default_nettype wire

// *** bench/vdm_misc_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module vdm_misc_regs_bench
    import vdm_pkg::*;
;
    logic        mclk, rst, psel, penable, pwrite, video_loss, noisy_signal, pix_valid_in;
    logic        pready, pslverr, pix_valid_out, colour_kill, err, ty;
    logic [7:0]  paddr, d;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic [15:0] rnd;
    logic [7:0]  sh [2];
    vdm_std_t    std_sel;
    vdm_detect_t detect_in;
    vdm_pixel_t  pix_in, pix_out, px;
    vdm_ctrl_t   ctrl;
    int          errors, tests_run, cyc;

    vdm_misc_regs dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .std_sel(std_sel), .video_loss(video_loss), .noisy_signal(noisy_signal), .detect_in(detect_in),
        .pix_valid_in(pix_valid_in), .pix_in(pix_in), .pix_valid_out(pix_valid_out), .pix_out(pix_out),
        .ctrl(ctrl), .colour_kill(colour_kill));

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Bits of i: force, loss enable, blue select, video lost
    function automatic vdm_pixel_t fill_exp(input logic [3:0] i, input vdm_pixel_t p);
        if (i[0] || i[1] && i[3])
            return i[2] ? {VDM_BLUE_Y, VDM_BLUE_CB, VDM_BLUE_CR} : {VDM_BLACK_Y, VDM_BLACK_CB, VDM_BLACK_CR};
        return p;
    endfunction

    function automatic logic kill_exp(input logic [1:0] s, input logic [2:0] k, input logic n);
        return n && (s == 2'h1 ? k[2] : s == 2'h2 ? k[1] : s == 2'h3 && k[0]);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dw, input logic [3:0] s);
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dw;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk);
        while (pready !== 1'h1)
            @(posedge mclk);
        r = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic results();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            results();
        end
    end

    initial
    begin
        {rst, psel, penable, pwrite, video_loss, noisy_signal, pix_valid_in} = 7'h40;
        {paddr, pwdata, pstrb, pix_in} = '0;
        std_sel = VDM_STD_NONE;
        detect_in = '0;
        rnd = 16'hF9B5;
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        apb(1'h0, VDM_ADDR_LOOP, 32'h0, 4'hF);
        chk(r, {24'h0, VDM_LOOP_RST});
        apb(1'h0, VDM_ADDR_KILL, 32'h0, 4'hF);
        chk(r, {24'h0, VDM_KILL_RST});
        apb(1'h0, VDM_ADDR_STAT, 32'h0, 4'hF);
        chk(r, 32'h0);
        $display("reset values done");
        sh[0] = VDM_LOOP_RST;
        sh[1] = VDM_KILL_RST;
        // Random data and strobes; lane 0 clear must leave the register alone
        for (int k = 0; k < 16; k++)
        begin
            rnd = lfsr(rnd);
            apb(1'h1, k[0] ? VDM_ADDR_KILL : VDM_ADDR_LOOP, {rnd, rnd}, rnd[11:8]);
            if (rnd[8])
                sh[k[0]] = rnd[7:0];
            apb(1'h0, k[0] ? VDM_ADDR_KILL : VDM_ADDR_LOOP, 32'h0, 4'hF);
            d = sh[k[0]];
            chk(r, {24'h0, d});
            if (k[0])
                chk({ctrl.special_output_sel, ctrl.blue_stretch_en}, {d[4], d[0]});
            else
                chk({ctrl.hloop_acquire_speed, ctrl.chroma_gain_time_const, ctrl.chroma_gain_on,
                    ctrl.burst_loop_speed, ctrl.chroma_lowpass_bw}, {d[7:4], |d[5:4], d[3:0]});
        end
        $display("register access done");
        for (int i = 0; i < 16; i++)
        begin
            apb(1'h1, VDM_ADDR_KILL, {28'h0, i[0], i[1], i[2], 1'h0}, 4'hF);
            rnd = lfsr(rnd);
            px = {rnd, rnd[7:0] ^ 8'h5A};
            video_loss <= i[3];
            pix_in <= px;
            pix_valid_in <= 1'h1;
            @(posedge mclk);
            pix_valid_in <= 1'h0;
            @(posedge mclk);
            chk(pix_out, fill_exp(i[3:0], px));
            chk(ctrl.fill_active, i[0] | (i[1] & i[3]));
        end
        $display("fill colour done");
        for (int j = 0; j < 16; j++)
        begin
            rnd = lfsr(rnd);
            apb(1'h1, VDM_ADDR_KILL, {24'h0, rnd[2:0], 5'h0}, 4'hF);
            std_sel <= vdm_std_t'(j[1:0]);
            noisy_signal <= j[2];
            repeat (3) @(posedge mclk);
            chk(colour_kill, kill_exp(j[1:0], rnd[2:0], j[2]));
            chk(ctrl.noise_killer_active, kill_exp(j[1:0], rnd[2:0], 1'h1));
        end
        $display("colour killer done");
        ty = 1'h0;
        for (int j = 0; j < 12; j++)
        begin
            rnd = lfsr(rnd);
            detect_in <= vdm_detect_t'(rnd[3:0]);
            if (rnd[1])
                ty = rnd[0];
            apb(1'h1, VDM_ADDR_STAT, 32'hFF, 4'hF);
            chk(err, 1'h0);
            apb(1'h0, VDM_ADDR_STAT, 32'h0, 4'hF);
            chk(r, {28'h0, rnd[3:1], ty});
        end
        $display("status done");
        // Mid-run reset must bring both writable registers back to their reset values
        rst <= 1'h1;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        apb(1'h0, VDM_ADDR_KILL, 32'h0, 4'hF);
        chk(r, {24'h0, VDM_KILL_RST});
        apb(1'h0, VDM_ADDR_LOOP, 32'h0, 4'hF);
        chk(r, {24'h0, VDM_LOOP_RST});
        $display("mid-run reset done");
        apb(1'h0, 8'hC4, 32'h0, 4'hF);
        chk(r, 32'h0);
        chk(err, 1'h1);
        $display("unmapped done");
        results();
    end
endmodule
`default_nettype wire
